// File: logic/erps_pkg.sv
// Package for the enable/reset power sequencer: timing counts and shared types.
// Assumes a 40 MHz core clock shared by both ends.
package erps_pkg;
    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 40000000;
    localparam int CLK_NS = 25;
    localparam int STOP_MS = 1000;
    localparam int STOP_CYC = STOP_MS * (CLK_HZ / 1000);
    localparam int EN_MIN_PS = 1200000;
    localparam int EN_MIN_CYC = (EN_MIN_PS + CLK_NS * 1000 - 1) / (CLK_NS * 1000);
    localparam int HOST_HOLD_CYC = EN_MIN_CYC + 2;
    // ------------------------------------------------------------
    // Field encodings
    // ------------------------------------------------------------
    localparam logic [1:0] FB_HALL_U = 2'h0;
    localparam logic [1:0] FB_PICKUP = 2'h2;
    localparam logic [7:0] DUTY_FULL = 8'hFF;
    localparam logic [7:0] DUTY_STEP = 8'h01;
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic POLARITY_RESET = 1'b0;
    localparam logic BRAKE_RESET = 1'b0;
    // ------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ERPS_UNCONF, ERPS_RUN, ERPS_STOPPING, ERPS_SLEEP, ERPS_RST_STOP, ERPS_RST_HOLD
    } erps_state_t;
endpackage

// File: logic/erps_if.sv
// Pin-level link between the host controller and the sequencer.
// Assumes both ends run on the same core clock.
`timescale 1ns/1ps
interface erps_if;
    logic enable_pin;
    logic reset_pin;
    logic config_source_select;
    logic cfg_wr;
    logic [7:0] cfg_data;
    logic otp_burn;
    logic speed_reference_clock;
    logic asleep;
    logic configured;
    modport device (
        input enable_pin, reset_pin, config_source_select, cfg_wr, cfg_data, otp_burn,
        input speed_reference_clock,
        output asleep, configured
    );
    modport host (
        output enable_pin, reset_pin, config_source_select, cfg_wr, cfg_data, otp_burn,
        output speed_reference_clock,
        input asleep, configured
    );
endinterface

// File: logic/erps_filter.sv
// Pulse-width filter for the enable pin: a level change is accepted only after
// it has held for a given number of cycles. Assumes a synchronous input.
`timescale 1ns/1ps
module erps_filter #(
    parameter int HOLD = 48
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic raw,
    output logic clean
);
    logic [15:0] cnt;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            cnt <= 16'h0000;
            clean <= 1'b1;
        end else if (raw == clean) begin
            cnt <= 16'h0000;
        end else if (cnt >= 16'(HOLD - 1)) begin
            cnt <= 16'h0000;
            clean <= raw;
        end else begin
            cnt <= cnt + 16'h0001;
        end
    end
endmodule

// File: logic/erps_device.sv
// Device end: enable/reset power sequencer of a brushless motor controller.
// Assumes synchronous pins from the host and a 40 MHz core clock.
//
// Overview of operation
// - Enable deassert starts stop and power-down
// - First disable outputs, brake or coast
// - Stopped means no speed pulse for 1 s
// - Power-down gates circuitry, Hall supply, clocks
// - Serial writes still accepted while asleep
// - Host holds enable off at least 1.2 us
// - Enable polarity change also starts sequence
// - Started sequence completes regardless of enable
// - Quick re-enable still waits 1 s stopped
// - Reset during power-down waits for re-enable
// - Reset while enabled: stop, reload, clear
// - Motor disabled while reset stays asserted
// - Tied reset/enable needs active-low polarity
// - Tied signal return reloads and starts motor
// - No motor drive until configured
// - Source pin high: load from EEPROM
// - Source pin low: host writes over serial
// - Burned configuration loads on power-up (here rst clears otp_reg; it loads on the reset reload or in ERPS_UNCONF while unconfigured)
// - Feedback select 00b Hall U, 10b pickup
// - Host supplies correct speed reference clock
// - Current above limit shortens drive duty
// - Open-loop duty command 0% to 100%
`timescale 1ns/1ps
module erps_device #(
    parameter int STOP_CYCLES = erps_pkg::STOP_CYC
) (
    input wire logic core_clk,
    input wire logic rst,
    erps_if.device link,
    input wire logic enable_polarity,
    input wire logic brake_mode_select,
    input wire logic [1:0] speed_feedback_select,
    input wire logic [7:0] duty_command,
    input wire logic closed_loop,
    input wire logic [7:0] eeprom_data,
    input wire logic current_limit_trip,
    input wire logic speed_pulse_output,
    input wire logic hall_u,
    input wire logic speed_pickup_input,
    output logic drive_on,
    output logic brake_on,
    output logic [7:0] drive_duty,
    output logic hall_supply_regulator,
    output logic power_switch,
    output logic clocks_running,
    output logic fault_clear,
    output logic loop_init,
    output logic speed_fb,
    output logic [7:0] config_reg
);
    erps_pkg::erps_state_t state;
    logic en_clean;
    logic en_active;
    logic rst_active;
    logic pol_q;
    logic pulse_q;
    logic pending_reset;
    logic [7:0] otp_reg;
    logic otp_valid;
    logic [31:0] quiet_cnt;
    logic stopped;

    // ------------------------------------------------------------
    // Enable filtering and polarity
    // ------------------------------------------------------------
    erps_filter #(.HOLD(erps_pkg::EN_MIN_CYC)) u_filter (
        .core_clk(core_clk),
        .rst(rst),
        .raw(link.enable_pin),
        .clean(en_clean)
    );
    // Tied pins work because the polarity inverts enable only
    assign en_active = en_clean ^ enable_polarity;
    assign rst_active = link.reset_pin;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            pol_q <= erps_pkg::POLARITY_RESET;
        end else begin
            pol_q <= enable_polarity;
        end
    end

    // ------------------------------------------------------------
    // Rotation detect: 1 s without speed pulse edges
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pulse_q <= 1'b0;
            quiet_cnt <= 32'h00000000;
        end else begin
            pulse_q <= speed_pulse_output;
            if (pulse_q != speed_pulse_output || state == erps_pkg::ERPS_RUN) begin
                quiet_cnt <= 32'h00000000;
            end else if (quiet_cnt < 32'(STOP_CYCLES)) begin
                quiet_cnt <= quiet_cnt + 32'h00000001;
            end
        end
    end
    assign stopped = (quiet_cnt >= 32'(STOP_CYCLES));

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            state <= erps_pkg::ERPS_UNCONF;
            pending_reset <= 1'b0;
        end else begin
            unique case (state)
                erps_pkg::ERPS_UNCONF: begin
                    if (link.configured && en_active && !rst_active) begin
                        state <= erps_pkg::ERPS_RUN;
                    end
                end
                erps_pkg::ERPS_RUN: begin
                    if (!en_active || pol_q != enable_polarity) begin
                        state <= erps_pkg::ERPS_STOPPING;
                    end else if (rst_active) begin
                        state <= erps_pkg::ERPS_RST_STOP;
                    end
                end
                erps_pkg::ERPS_STOPPING: begin
                    if (rst_active) begin
                        pending_reset <= 1'b1;
                    end
                    if (stopped) begin
                        state <= erps_pkg::ERPS_SLEEP;
                    end
                end
                erps_pkg::ERPS_SLEEP: begin
                    if (rst_active) begin
                        pending_reset <= 1'b1;
                    end
                    if (en_active) begin
                        pending_reset <= 1'b0;
                        if (pending_reset || rst_active) begin
                            state <= erps_pkg::ERPS_RST_STOP;
                        end else begin
                            state <= erps_pkg::ERPS_UNCONF;
                        end
                    end
                end
                erps_pkg::ERPS_RST_STOP: begin
                    if (stopped) begin
                        state <= erps_pkg::ERPS_RST_HOLD;
                    end
                end
                erps_pkg::ERPS_RST_HOLD: begin
                    if (!rst_active) begin
                        state <= erps_pkg::ERPS_UNCONF;
                    end
                end
                default: begin
                    state <= erps_pkg::ERPS_UNCONF;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Configuration: serial writes, EEPROM, OTP
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            config_reg <= erps_pkg::CFG_RESET;
            otp_reg <= erps_pkg::CFG_RESET;
            otp_valid <= 1'b0;
            link.configured <= 1'b0;
        end else begin
            if (state == erps_pkg::ERPS_RST_STOP && stopped) begin
                config_reg <= otp_reg;
                link.configured <= otp_valid;
            end else if (!link.config_source_select && link.cfg_wr) begin
                config_reg <= link.cfg_data;
                link.configured <= 1'b1;
            end else if (link.config_source_select && state == erps_pkg::ERPS_UNCONF
                         && !link.configured) begin
                config_reg <= eeprom_data;
                link.configured <= 1'b1;
            end else if (otp_valid && state == erps_pkg::ERPS_UNCONF
                         && !link.configured) begin
                config_reg <= otp_reg;
                link.configured <= 1'b1;
            end
            if (!link.config_source_select && link.otp_burn && !otp_valid) begin
                otp_reg <= config_reg;
                otp_valid <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Drive outputs, power gating, feedback select
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            drive_on <= 1'b0;
            brake_on <= erps_pkg::BRAKE_RESET;
            drive_duty <= 8'h00;
            hall_supply_regulator <= 1'b1;
            power_switch <= 1'b1;
            clocks_running <= 1'b1;
            link.asleep <= 1'b0;
            fault_clear <= 1'b0;
            loop_init <= 1'b0;
            speed_fb <= 1'b0;
        end else begin
            drive_on <= (state == erps_pkg::ERPS_RUN);
            brake_on <= (state == erps_pkg::ERPS_STOPPING || state == erps_pkg::ERPS_RST_STOP)
                        && brake_mode_select;
            if (state != erps_pkg::ERPS_RUN) begin
                drive_duty <= 8'h00;
            end else if (current_limit_trip) begin
                if (drive_duty > erps_pkg::DUTY_STEP) begin
                    drive_duty <= drive_duty - erps_pkg::DUTY_STEP;
                end else begin
                    drive_duty <= 8'h00;
                end
            end else if (!closed_loop) begin
                drive_duty <= duty_command;
            end else begin
                drive_duty <= erps_pkg::DUTY_FULL;
            end
            hall_supply_regulator <= (state != erps_pkg::ERPS_SLEEP);
            power_switch <= (state != erps_pkg::ERPS_SLEEP);
            clocks_running <= (state != erps_pkg::ERPS_SLEEP);
            link.asleep <= (state == erps_pkg::ERPS_SLEEP);
            fault_clear <= (state == erps_pkg::ERPS_RST_STOP) && stopped;
            loop_init <= (state == erps_pkg::ERPS_RST_STOP) && stopped;
            speed_fb <= (speed_feedback_select == erps_pkg::FB_PICKUP) ? speed_pickup_input
                      : hall_u;
        end
    end
endmodule

// File: logic/erps_host.sv
// Host end: drives enable, reset, configuration source and serial writes.
// Assumes the device end on the same core clock.
`timescale 1ns/1ps
module erps_host (
    input wire logic core_clk,
    input wire logic rst,
    erps_if.host link,
    input wire logic req_enable,
    input wire logic req_reset,
    input wire logic use_eeprom,
    input wire logic wr_req,
    input wire logic [7:0] wr_data,
    input wire logic burn_req,
    input wire logic ref_clk_in,
    output logic device_asleep,
    output logic device_configured
);
    logic [7:0] hold_cnt;

    // ------------------------------------------------------------
    // Enable with minimum deassert width
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            link.enable_pin <= 1'b1;
            hold_cnt <= 8'h00;
        end else if (!link.enable_pin && hold_cnt < 8'(erps_pkg::HOST_HOLD_CYC)) begin
            hold_cnt <= hold_cnt + 8'h01;
        end else begin
            link.enable_pin <= req_enable;
            hold_cnt <= 8'h00;
        end
    end

    // ------------------------------------------------------------
    // Reset, source select, serial writes, reference clock
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            link.reset_pin <= 1'b0;
            link.config_source_select <= 1'b0;
            link.cfg_wr <= 1'b0;
            link.cfg_data <= 8'h00;
            link.otp_burn <= 1'b0;
            link.speed_reference_clock <= 1'b0;
            device_asleep <= 1'b0;
            device_configured <= 1'b0;
        end else begin
            link.reset_pin <= req_reset;
            link.config_source_select <= use_eeprom;
            link.cfg_wr <= wr_req && !use_eeprom;
            link.cfg_data <= wr_data;
            link.otp_burn <= burn_req && !use_eeprom;
            link.speed_reference_clock <= ref_clk_in;
            device_asleep <= link.asleep;
            device_configured <= link.configured;
        end
    end
endmodule

// File: bench/erps_assertions.sv
// Checker for the host/device link and the device outputs.
// Assumes one clock domain; instantiated beside the interface.
`timescale 1ns/1ps
module erps_assertions #(
    parameter int STOP_CYCLES = 200
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic cfg_wr,
    input wire logic config_source_select,
    input wire logic [7:0] cfg_data,
    input wire logic reset_pin,
    input wire logic asleep,
    input wire logic configured,
    input wire logic drive_on,
    input wire logic brake_on,
    input wire logic brake_mode_select,
    input wire logic [7:0] config_reg,
    input wire logic hall_supply_regulator,
    input wire logic power_switch,
    input wire logic clocks_running,
    input wire logic fault_clear,
    input wire logic loop_init,
    input wire logic speed_pulse_output,
    input wire logic [1:0] speed_feedback_select,
    input wire logic speed_fb,
    input wire logic hall_u,
    input wire logic speed_pickup_input,
    input wire logic current_limit_trip,
    input wire logic [7:0] drive_duty
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    // ------------------------------------------------------------
    // Quiet time of the speed pulse
    // ------------------------------------------------------------
    int quiet_cnt;
    logic pulse_q;
    always_ff @(posedge core_clk) begin
        pulse_q <= speed_pulse_output;
        if (rst || pulse_q != speed_pulse_output) begin
            quiet_cnt <= 0;
        end else if (quiet_cnt < STOP_CYCLES) begin
            quiet_cnt <= quiet_cnt + 1;
        end
    end
    a_sleep_power_off: assert property (
        asleep && $past(asleep) |-> !drive_on && !hall_supply_regulator && !power_switch
        && !clocks_running) else $error("power left on in sleep");
    a_quiet_before_sleep: assert property (
        $rose(asleep) |-> quiet_cnt >= STOP_CYCLES - 2) else $error("sleep before quiet time");
    a_stop_brake_mode: assert property (
        $fell(drive_on) && $stable(brake_mode_select) |-> brake_on == brake_mode_select)
        else $error("brake mode wrong at stop");
    a_cfg_write_taken: assert property (
        cfg_wr && !config_source_select |=> configured && config_reg == $past(cfg_data))
        else $error("serial write not taken");
    a_reload_pulses: assert property (
        fault_clear |-> loop_init && !drive_on) else $error("reload pulses not paired");
    a_reset_holds_off: assert property (
        reset_pin [*5] |-> !drive_on) else $error("motor driven under reset");
    a_fb_pickup: assert property (
        !asleep && speed_feedback_select == erps_pkg::FB_PICKUP |=>
        asleep || speed_fb == $past(speed_pickup_input)) else $error("pickup not selected");
    a_fb_hall: assert property (
        !asleep && speed_feedback_select == erps_pkg::FB_HALL_U |=>
        asleep || speed_fb == $past(hall_u)) else $error("hall not selected");
    a_limit_trims: assert property (
        current_limit_trip && $past(current_limit_trip) && drive_on && drive_duty != 8'h00
        |=> !drive_on || drive_duty < $past(drive_duty)) else $error("duty not trimmed");
endmodule

// File: bench/test_enable_reset_power_sequencer.sv
// Testbench: host and device joined by the link, user sides driven.
// Assumes a shortened stop count and the checker beside the link.
`timescale 1ns/1ps
module test_enable_reset_power_sequencer;
    localparam int STOP = 200;
    typedef struct {string what; logic [7:0] exp;} erps_note_t;
    erps_note_t notes[$];
    logic core_clk, rst, req_enable, req_reset, use_eeprom, wr_req, burn_req, ref_clk_in;
    logic enable_polarity, brake_mode_select, current_limit_trip, speed_pulse_output;
    logic hall_u, speed_pickup_input, spin, drive_on, brake_on, hall_supply_regulator, closed_loop;
    logic power_switch, clocks_running, fault_clear, loop_init, speed_fb, dev_asleep, dev_conf;
    logic [1:0] speed_feedback_select;
    logic [7:0] wr_data, duty_command, eeprom_data, drive_duty, config_reg, d1, v;
    int err_total = 0;
    int n_checks = 0;
    int cyc = 0;
    erps_if link();
    erps_host erps_host_i (.core_clk(core_clk), .rst(rst), .link(link.host),
        .req_enable(req_enable), .req_reset(req_reset), .use_eeprom(use_eeprom),
        .wr_req(wr_req), .wr_data(wr_data), .burn_req(burn_req), .ref_clk_in(ref_clk_in),
        .device_asleep(dev_asleep), .device_configured(dev_conf));
    erps_device #(.STOP_CYCLES(STOP)) erps_device_i (.core_clk(core_clk), .rst(rst),
        .link(link.device), .enable_polarity(enable_polarity),
        .brake_mode_select(brake_mode_select), .speed_feedback_select(speed_feedback_select),
        .duty_command(duty_command), .closed_loop(closed_loop), .eeprom_data(eeprom_data),
        .current_limit_trip(current_limit_trip), .speed_pulse_output(speed_pulse_output),
        .hall_u(hall_u), .speed_pickup_input(speed_pickup_input), .drive_on(drive_on),
        .brake_on(brake_on), .drive_duty(drive_duty),
        .hall_supply_regulator(hall_supply_regulator), .power_switch(power_switch),
        .clocks_running(clocks_running), .fault_clear(fault_clear), .loop_init(loop_init),
        .speed_fb(speed_fb), .config_reg(config_reg));
    erps_assertions #(.STOP_CYCLES(STOP)) erps_assertions_i (.core_clk(core_clk), .rst(rst),
        .cfg_wr(link.cfg_wr), .config_source_select(link.config_source_select),
        .cfg_data(link.cfg_data), .reset_pin(link.reset_pin), .asleep(link.asleep),
        .configured(link.configured), .drive_on(drive_on), .brake_on(brake_on),
        .brake_mode_select(brake_mode_select), .config_reg(config_reg),
        .hall_supply_regulator(hall_supply_regulator), .power_switch(power_switch),
        .clocks_running(clocks_running), .fault_clear(fault_clear), .loop_init(loop_init),
        .speed_pulse_output(speed_pulse_output), .speed_feedback_select(speed_feedback_select),
        .speed_fb(speed_fb), .hall_u(hall_u), .speed_pickup_input(speed_pickup_input),
        .current_limit_trip(current_limit_trip), .drive_duty(drive_duty));
    // ------------------------------------------------------------
    // Checking and closing
    // ------------------------------------------------------------
    task check(string what, logic [7:0] seen, logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task close_out();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    function automatic logic [7:0] pick(string s);
        case (s)
            "config_reg": return config_reg;
            "drive_duty": return drive_duty;
            "drive_on": return {7'h00, drive_on};
            "brake_on": return {7'h00, brake_on};
            "asleep": return {7'h00, dev_asleep};
            "hall_supply": return {7'h00, hall_supply_regulator};
            "configured": return {7'h00, dev_conf};
            default: return {7'h00, speed_fb};
        endcase
    endfunction
    task note(string what, logic [7:0] exp);
        notes.push_back('{what, exp});
    endtask
    task step(int n);
        repeat (n) @(posedge core_clk);
        #2;
    endtask
    task wr(logic [7:0] val);
        wr_data = val;
        wr_req = 1;
        step(1);
        wr_req = 0;
        step(3);
        note("config_reg", val);
    endtask
    initial begin
        core_clk = 0;
        forever #12.5 core_clk = ~core_clk;
    end
    always @(negedge core_clk) begin
        cyc <= cyc + 1;
        while (notes.size() > 0) begin
            check(notes[0].what, pick(notes[0].what), notes[0].exp);
            void'(notes.pop_front());
        end
        if (cyc == 20000) begin
            err_total++;
            close_out();
        end
    end
    always @(posedge core_clk) begin
        #2;
        ref_clk_in = ~ref_clk_in;
        if (spin) begin
            speed_pulse_output = ~speed_pulse_output;
        end
    end
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        {rst, req_enable} = 2'b11;
        {req_reset, use_eeprom, wr_req, burn_req, ref_clk_in, enable_polarity} = 6'h00;
        {brake_mode_select, current_limit_trip, speed_pulse_output, spin} = 4'h0;
        {closed_loop, hall_u, speed_pickup_input, speed_feedback_select} = 5'h00;
        {wr_data, duty_command, eeprom_data} = 24'h000000;
        void'($urandom(32'h3375));
        d1 = 8'($urandom());
        step(6);
        rst = 0;
        step(20);
        note("drive_on", 8'h00);
        note("configured", 8'h00);
        wr(d1);
        burn_req = 1;
        step(1);
        burn_req = 0;
        step(10);
        note("drive_on", 8'h01);
        note("configured", 8'h01);
        foreach (d1[i]) begin
            duty_command = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($urandom());
            step(4);
            note("drive_duty", duty_command);
            speed_feedback_select = i[0] ? 2'h2 : 2'h0;
            {hall_u, speed_pickup_input} = 2'($urandom());
            step(3);
            note("speed_fb", {7'h00, i[0] ? speed_pickup_input : hall_u});
        end
        closed_loop = 1;
        step(3);
        note("drive_duty", erps_pkg::DUTY_FULL);
        closed_loop = 0;
        duty_command = 8'h80;
        step(3);
        current_limit_trip = 1;
        step(6);
        note("drive_duty", 8'h7A);
        current_limit_trip = 0;
        step(3);
        note("drive_duty", 8'h80);
        $display("configuration, duty and feedback done");
        wr(d1 ^ 8'h3C);
        brake_mode_select = 1;
        spin = 1;
        req_enable = 0;
        step(60);
        note("drive_on", 8'h00);
        note("brake_on", 8'h01);
        step(STOP);
        note("asleep", 8'h00);
        spin = 0;
        step(STOP + 20);
        note("asleep", 8'h01);
        note("hall_supply", 8'h00);
        wr(d1 ^ 8'hC3);
        req_reset = 1;
        step(10);
        req_enable = 1;
        step(STOP + 100);
        note("config_reg", d1);
        note("drive_on", 8'h00);
        req_reset = 0;
        step(40);
        note("drive_on", 8'h01);
        $display("sleep and reset done");
        brake_mode_select = 0;
        req_enable = 0;
        step(1);
        req_enable = 1;
        step(60);
        note("drive_on", 8'h00);
        note("brake_on", 8'h00);
        step(STOP / 2);
        note("drive_on", 8'h00);
        step(STOP + 150);
        note("drive_on", 8'h01);
        $display("quick re-enable done");
        wr(d1 ^ 8'h99);
        enable_polarity = 1;
        step(10);
        note("drive_on", 8'h00);
        req_enable = 0;
        step(2 * STOP + 200);
        note("drive_on", 8'h01);
        {req_enable, req_reset} = 2'b11;
        step(60);
        note("drive_on", 8'h00);
        step(STOP + 100);
        {req_enable, req_reset} = 2'b00;
        step(2 * STOP + 150);
        note("config_reg", d1);
        note("drive_on", 8'h01);
        $display("polarity and tied pins done");
        {use_eeprom, req_enable, rst} = 3'h7;
        enable_polarity = 0;
        v = 8'($urandom());
        eeprom_data = v;
        step(6);
        rst = 0;
        step(14);
        note("config_reg", v);
        note("drive_on", 8'h01);
        step(2);
        $display("eeprom load done");
        close_out();
    end
endmodule
